// ===== design/bam_defines.vh
// constants for the b side bus alarm monitor
`ifndef BAM_DEFINES_VH
`define BAM_DEFINES_VH

// register offsets
`define BAM_ADDR_BUS_LIVE 8'h27
`define BAM_ADDR_PROC_LAT 8'h28
`define BAM_ADDR_PROC_LIVE 8'h29
`define BAM_ADDR_CFG 8'h2a
`define BAM_ADDR_BUS_LAT 8'h2b
`define BAM_ADDR_BUS_MASK 8'h2c
`define BAM_ADDR_PROC_MASK 8'h2d

// bus alarm register fields
`define BAM_BUS_DLOC 7
`define BAM_BUS_ALOC 6
`define BAM_BUS_DPAR 5
`define BAM_BUS_AIS_HI 2
`define BAM_BUS_AIS_LO 0

// processor and h4 alarm register fields
`define BAM_PROC_LOC 7
`define BAM_PROC_WDT 6
`define BAM_PROC_IRAM_PARITY_ERROR 4
`define BAM_PROC_H4_HI 2
`define BAM_PROC_H4_LO 0

// configuration register fields
`define BAM_CFG_AIS_SEL 0
`define BAM_CFG_H4_SEL 1
`define BAM_CFG_ADD_TIM 2
`define BAM_CFG_SINGLE 3
`define BAM_CFG_PAR_ODD 4
`define BAM_CFG_USED 8'h1f
`define BAM_CFG_RESET 8'h00
`define BAM_MASK_RESET 8'h00
`define BAM_ZERO8 8'h00

// clock loss window
`define BAM_CLK_PERIOD_NS 8
`define BAM_LOC_TIME_NS 1000
// 1000 ns at an 8 ns clock, sized for the 8-bit window counter
`define BAM_LOC_CYCLES 8'h7d

// h4 multiframe
`define BAM_H4_LAST 2'h3
`define BAM_H4_FIRST 2'h0
`define BAM_H4_BAD_LIMIT 2'h2

`endif

// ===== design/bam_monitor.v
// b side drop/add bus and processor alarm monitor with register port
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
`include "bam_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// stuck clock detector on a sampled clock level
module bam_loss_det (
  // clock and reset
  input wire mclk,
  input wire rst_b,
  input wire ce,
  // monitored level
  input wire lvl,
  // result
  output reg loss_reg
);
  localparam [7:0] LOC_LIM = `BAM_LOC_CYCLES;
  reg lvl_reg;
  reg [7:0] cnt_reg;
  wire edge_seen;

  assign edge_seen = lvl != lvl_reg;

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lvl_reg <= 1'b0;
      cnt_reg <= 8'h00;
      loss_reg <= 1'b0;
    end else if (ce) begin
      lvl_reg <= lvl;
      if (edge_seen) begin
        cnt_reg <= 8'h00;
        loss_reg <= 1'b0;
      end else if (cnt_reg < LOC_LIM) begin
        cnt_reg <= cnt_reg + 8'h01;
      end else begin
        loss_reg <= 1'b1;
      end
    end
  end
endmodule // bam_loss_det

////////////////////////////////////////////////////////////////////////////////
// h4 multiframe loss detector for one tributary
module bam_h4_det (
  // clock and reset
  input wire mclk,
  input wire rst_b,
  input wire ce,
  // h4 byte of this tributary seen
  input wire h4_stb,
  input wire [1:0] h4_val,
  // detector enabled
  input wire enable,
  // result
  output wire mf_loss
);
  reg [1:0] exp_reg;
  reg mis_reg;
  reg [1:0] bad_reg;
  reg [2:0] seq_reg;
  reg loss_reg;
  wire mismatch;
  wire mf_end;
  wire mf_bad;
  wire seq_done;

  assign mismatch = h4_val != exp_reg;
  assign mf_end = exp_reg == `BAM_H4_LAST;
  assign mf_bad = mis_reg | mismatch;
  // relock after a full 00,01,10,11 run
  assign seq_done = (seq_reg[1:0] == `BAM_H4_LAST) && (h4_val == `BAM_H4_LAST);
  assign mf_loss = enable & loss_reg;

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      exp_reg <= `BAM_H4_FIRST;
      mis_reg <= 1'b0;
      bad_reg <= 2'h0;
      seq_reg <= 3'h0;
      loss_reg <= 1'b1;
    end else if (ce) begin
      if (!enable) begin
        mis_reg <= 1'b0;
        bad_reg <= 2'h0;
        seq_reg <= 3'h0;
      end else if (h4_stb) begin
        // free running expected value
        exp_reg <= exp_reg + 2'h1;
        if (h4_val == `BAM_H4_FIRST) begin
          seq_reg <= 3'h1;
        end else if (h4_val == seq_reg[1:0] && seq_reg != 3'h0) begin
          seq_reg <= seq_reg + 3'h1;
        end else begin
          seq_reg <= 3'h0;
        end
        if (loss_reg && seq_done) begin
          exp_reg <= `BAM_H4_FIRST;
          loss_reg <= 1'b0;
          mis_reg <= 1'b0;
          bad_reg <= 2'h0;
          seq_reg <= 3'h0;
        end else if (mf_end) begin
          mis_reg <= 1'b0;
          if (!mf_bad) begin
            bad_reg <= 2'h0;
          end else if (bad_reg + 2'h1 >= `BAM_H4_BAD_LIMIT) begin
            loss_reg <= 1'b1;
            bad_reg <= `BAM_H4_BAD_LIMIT;
          end else begin
            bad_reg <= bad_reg + 2'h1;
          end
        end else begin
          mis_reg <= mf_bad;
        end
      end
    end
  end
endmodule // bam_h4_det

////////////////////////////////////////////////////////////////////////////////
// top: alarm monitor
module bam_monitor (
  // clock, reset, enable
  input wire mclk,
  input wire rst_b,
  input wire ce,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // interrupt
  output wire irq,
  // b drop bus pins
  input wire drop_clk,
  input wire [7:0] drop_data,
  input wire drop_par,
  input wire [2:0] drop_h4_mark,
  // b add bus clock pin
  input wire add_clk,
  // upstream ais indications per tributary
  input wire [2:0] ais_pointer,
  input wire [2:0] ais_overhead,
  // desynchronizer clock pin
  input wire desync_clock_input,
  // internal processor events
  input wire watchdog_expired,
  input wire iram_parity_error,
  // add data from the mapper
  input wire [7:0] add_data_in,
  input wire add_par_in,
  input wire add_ind_in,
  // b add bus pins
  output reg [7:0] add_data_o,
  output reg [7:0] add_data_oe,
  output reg add_par_o,
  output reg add_par_oe,
  output reg add_ind_o,
  // processor clock
  output reg proc_clk_reg
);
  localparam SYNC_W = 21;

  reg rst_s1_reg;
  reg rst_s2_reg;
  wire rst_i_b;
  reg [SYNC_W-1:0] pin_s1_reg;
  reg [SYNC_W-1:0] pin_s2_reg;
  wire [SYNC_W-1:0] pin_raw;
  reg drop_clk_d_reg;
  reg desync_d_reg;
  wire drop_rise;
  wire desync_rise;
  wire s_drop_clk;
  wire s_add_clk;
  wire s_desync;
  wire [7:0] s_data;
  wire s_par;
  wire [2:0] s_h4_mark;
  wire [2:0] s_ais_ptr;
  wire [2:0] s_ais_oh;
  reg [7:0] cfg_reg;
  reg [7:0] bus_lat_reg;
  reg [7:0] proc_lat_reg;
  reg [7:0] bus_mask_reg;
  reg [7:0] proc_mask_reg;
  reg par_err_reg;
  reg wdt_reg;
  reg iram_parity_error_reg;
  wire drop_loss;
  wire add_loss_raw;
  wire proc_loss;
  wire b_drop_clock_loss;
  wire b_add_clock_loss;
  wire [2:0] ais_live;
  wire [2:0] h4_loss;
  wire [2:0] h4_en;
  wire single_fmt;
  wire add_timing;
  wire par_mismatch;
  wire add_float;
  wire [7:0] bus_live;
  wire [7:0] proc_live;
  wire wr_proc_lat;
  wire wr_bus_lat;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_i_b = rst_s2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  assign pin_raw = {drop_clk, add_clk, desync_clock_input, drop_data, drop_par,
                    drop_h4_mark, ais_pointer, ais_overhead};

  always @(posedge mclk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      pin_s1_reg <= {SYNC_W{1'b0}};
      pin_s2_reg <= {SYNC_W{1'b0}};
    end else if (ce) begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  assign s_drop_clk = pin_s2_reg[20];
  assign s_add_clk = pin_s2_reg[19];
  assign s_desync = pin_s2_reg[18];
  assign s_data = pin_s2_reg[17:10];
  assign s_par = pin_s2_reg[9];
  assign s_h4_mark = pin_s2_reg[8:6];
  assign s_ais_ptr = pin_s2_reg[5:3];
  assign s_ais_oh = pin_s2_reg[2:0];

  // edge finding on synchronised clocks
  always @(posedge mclk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      drop_clk_d_reg <= 1'b0;
      desync_d_reg <= 1'b0;
      proc_clk_reg <= 1'b0;
    end else if (ce) begin
      drop_clk_d_reg <= s_drop_clk;
      desync_d_reg <= s_desync;
      if (desync_rise) begin
        proc_clk_reg <= ~proc_clk_reg;
      end
    end
  end
  assign drop_rise = s_drop_clk & ~drop_clk_d_reg;
  assign desync_rise = s_desync & ~desync_d_reg;

  ////////////////////////////////////////////////////////////////////////////
  // clock loss detectors
  bam_loss_det u_drop_loc (
    .mclk(mclk),
    .rst_b(rst_i_b),
    .ce(ce),
    .lvl(s_drop_clk),
    .loss_reg(drop_loss)
  );

  bam_loss_det u_add_loc (
    .mclk(mclk),
    .rst_b(rst_i_b),
    .ce(ce),
    .lvl(s_add_clk),
    .loss_reg(add_loss_raw)
  );

  bam_loss_det u_proc_loc (
    .mclk(mclk),
    .rst_b(rst_i_b),
    .ce(ce),
    .lvl(proc_clk_reg),
    .loss_reg(proc_loss)
  );

  assign single_fmt = cfg_reg[`BAM_CFG_SINGLE];
  assign add_timing = cfg_reg[`BAM_CFG_ADD_TIM];
  assign b_drop_clock_loss = drop_loss;
  assign b_add_clock_loss = add_timing & add_loss_raw;
  assign add_float = (~add_timing & drop_loss) | b_add_clock_loss;

  ////////////////////////////////////////////////////////////////////////////
  // add bus drive
  always @(posedge mclk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      add_data_o <= 8'h00;
      add_data_oe <= 8'h00;
      add_par_o <= 1'b0;
      add_par_oe <= 1'b0;
      add_ind_o <= 1'b0;
    end else if (ce) begin
      add_data_o <= add_data_in;
      add_par_o <= add_par_in;
      add_data_oe <= {8{~add_float}};
      add_par_oe <= ~add_float;
      add_ind_o <= add_ind_in & ~add_float;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drop bus parity, held until next drop clock
  assign par_mismatch = (^{s_data, s_par}) ^ cfg_reg[`BAM_CFG_PAR_ODD];

  always @(posedge mclk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      par_err_reg <= 1'b0;
      wdt_reg <= 1'b0;
      iram_parity_error_reg <= 1'b0;
    end else if (ce) begin
      if (drop_rise) begin
        par_err_reg <= par_mismatch;
      end
      wdt_reg <= watchdog_expired;
      iram_parity_error_reg <= iram_parity_error;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // upstream ais select
  assign ais_live[0] = cfg_reg[`BAM_CFG_AIS_SEL] ? s_ais_oh[0] : s_ais_ptr[0];
  assign ais_live[2:1] = (cfg_reg[`BAM_CFG_AIS_SEL] ? s_ais_oh[2:1] : s_ais_ptr[2:1])
                         & {2{~single_fmt}};

  ////////////////////////////////////////////////////////////////////////////
  // h4 detectors
  assign h4_en[0] = ~cfg_reg[`BAM_CFG_H4_SEL];
  assign h4_en[2:1] = {2{~cfg_reg[`BAM_CFG_H4_SEL] & ~single_fmt}};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_h4
      bam_h4_det u_h4 (
        .mclk(mclk),
        .rst_b(rst_i_b),
        .ce(ce),
        .h4_stb(drop_rise & s_h4_mark[gi]),
        .h4_val(s_data[7:6]),
        .enable(h4_en[gi]),
        .mf_loss(h4_loss[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // live registers
  assign bus_live = {b_drop_clock_loss, b_add_clock_loss, par_err_reg, 2'b00, ais_live};
  assign proc_live = {proc_loss, wdt_reg, 1'b0, iram_parity_error_reg, 1'b0, h4_loss};

  ////////////////////////////////////////////////////////////////////////////
  // software writes and latched bits, set wins over clear
  assign wr_proc_lat = reg_wr && reg_addr == `BAM_ADDR_PROC_LAT;
  assign wr_bus_lat = reg_wr && reg_addr == `BAM_ADDR_BUS_LAT;

  always @(posedge mclk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      cfg_reg <= `BAM_CFG_RESET;
      bus_mask_reg <= `BAM_MASK_RESET;
      proc_mask_reg <= `BAM_MASK_RESET;
      proc_lat_reg <= `BAM_ZERO8;
      bus_lat_reg <= `BAM_ZERO8;
    end else if (ce) begin
      if (reg_wr && reg_addr == `BAM_ADDR_CFG) begin
        cfg_reg <= reg_wdata & `BAM_CFG_USED;
      end
      if (reg_wr && reg_addr == `BAM_ADDR_BUS_MASK) begin
        bus_mask_reg <= reg_wdata;
      end
      if (reg_wr && reg_addr == `BAM_ADDR_PROC_MASK) begin
        proc_mask_reg <= reg_wdata;
      end
      proc_lat_reg <= (proc_lat_reg & ~(wr_proc_lat ? reg_wdata : `BAM_ZERO8)) | proc_live;
      bus_lat_reg <= (bus_lat_reg & ~(wr_bus_lat ? reg_wdata : `BAM_ZERO8)) | bus_live;
    end
  end

  assign irq = |(proc_lat_reg & proc_mask_reg) | |(bus_lat_reg & bus_mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // read data, valid only in the cycle after the strobe
  always @(posedge mclk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `BAM_ADDR_BUS_LIVE: reg_rdata <= bus_live;
          `BAM_ADDR_PROC_LAT: reg_rdata <= proc_lat_reg;
          `BAM_ADDR_PROC_LIVE: reg_rdata <= proc_live;
          `BAM_ADDR_CFG: reg_rdata <= cfg_reg;
          `BAM_ADDR_BUS_LAT: reg_rdata <= bus_lat_reg;
          `BAM_ADDR_BUS_MASK: reg_rdata <= bus_mask_reg;
          `BAM_ADDR_PROC_MASK: reg_rdata <= proc_mask_reg;
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule // bam_monitor

// ===== sim/bam_monitor_asserts.sv
// concurrent checks on the alarm monitor ports
`timescale 1ns/1ns
module bam_monitor_asserts (
  // clock and reset
  input wire mclk,
  input wire rst_b,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // add bus and processor clock
  input wire [7:0] add_data_oe,
  input wire add_par_oe,
  input wire add_ind_o,
  input wire desync_clock_input,
  input wire proc_clk_reg
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  reg rd_d_reg;
  reg [7:0] addr_d_reg;
  reg [7:0] lat_exp_reg;
  ////////////////////////////////////////////////////////////////////////////////
  // live bits seen set and not yet cleared by software
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_d_reg <= 1'b0;
      addr_d_reg <= 8'h00;
      lat_exp_reg <= 8'h00;
    end else begin
      rd_d_reg <= reg_rd;
      addr_d_reg <= reg_addr;
      if (reg_wr && reg_addr == 8'h28) begin
        lat_exp_reg <= lat_exp_reg & ~reg_wdata;
      end else if (rd_d_reg && addr_d_reg == 8'h29) begin
        lat_exp_reg <= lat_exp_reg | reg_rdata;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  AST_RD_QUIET: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  AST_BUS_UNUSED: assert property ($past(reg_rd) && $past(reg_addr) == 8'h27 |-> reg_rdata[4:3] == 2'h0)
    else $error("bus alarm unused bits set");
  AST_PROC_UNUSED: assert property ($past(reg_rd) && ($past(reg_addr) inside {8'h28, 8'h29})
    |-> !reg_rdata[5] && !reg_rdata[3]) else $error("processor alarm unused bits set");
  AST_OE_GROUP: assert property (add_data_oe == {8{add_par_oe}})
    else $error("add data and parity enables disagree");
  AST_IND_OFF: assert property (!add_par_oe |-> !add_ind_o)
    else $error("add indicator on while bus floated");
  AST_PCLK_HOLD: assert property ($stable(desync_clock_input) [*8] |=> $stable(proc_clk_reg))
    else $error("processor clock moved without desync clock");
  AST_PCLK_RATE: assert property ($changed(proc_clk_reg) |=> $stable(proc_clk_reg))
    else $error("processor clock above half rate");
  AST_LATCH_HOLDS: assert property (rd_d_reg && addr_d_reg == 8'h28
    |-> (reg_rdata & lat_exp_reg) == lat_exp_reg) else $error("latched bit lost");
  cover property (!add_par_oe);
  cover property ($changed(proc_clk_reg));
  cover property (rd_d_reg && addr_d_reg == 8'h28 && lat_exp_reg != 8'h00);
endmodule // bam_monitor_asserts

// ===== sim/bam_drop_source.sv
// drop and add bus source standing in for the overhead terminator
`timescale 1ns/1ns
module bam_drop_source (
  // controls
  input wire drop_en,
  input wire add_en,
  input wire par_bad,
  input wire h4_bad,
  // drop bus and add clock
  output reg drop_clk,
  output reg [7:0] drop_data,
  output reg drop_par,
  output reg [2:0] drop_h4_mark,
  output reg add_clk
);
  reg [1:0] h4_reg = 2'h0;
  reg [1:0] slot_reg = 2'h0;
  initial begin
    drop_clk = 1'b0;
    drop_data = 8'h00;
    drop_par = 1'b0;
    drop_h4_mark = 3'h0;
    add_clk = 1'b0;
  end
  // clocks stand still while disabled
  always begin
    #62;
    if (add_en) add_clk = ~add_clk;
    #63;
    if (add_en) add_clk = ~add_clk;
  end
  // one h4 byte per four-byte frame on all tributaries
  always begin
    #63;
    if (drop_en) begin
      drop_clk = 1'b1;
      #62;
      drop_clk = 1'b0;
      slot_reg = slot_reg + 2'h1;
      drop_h4_mark = (slot_reg == 2'h0) ? 3'h7 : 3'h0;
      drop_data = {(h4_bad ? 2'h0 : h4_reg), 4'h5, slot_reg};
      if (slot_reg == 2'h0) h4_reg = h4_reg + 2'h1;
      drop_par = ^drop_data ^ par_bad;
    end else begin
      // stale lines keep changing
      #62;
      drop_data = ~drop_data;
      drop_par = ~drop_par;
    end
  end
endmodule // bam_drop_source

// ===== sim/bam_monitor_bench.sv
// self-checking bench for the b side alarm monitor
`timescale 1ns/1ns
module bam_monitor_bench;
  reg mclk = 1'b0;
  reg rst_b = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [2:0] ais_pointer = 3'h0;
  reg [2:0] ais_overhead = 3'h0;
  reg desync_clock_input = 1'b0;
  reg desync_en = 1'b1;
  reg watchdog_expired = 1'b0;
  reg iram_parity_error = 1'b0;
  reg drop_en = 1'b0;
  reg add_en = 1'b1;
  reg par_bad = 1'b0;
  reg h4_bad = 1'b0;
  wire [7:0] reg_rdata, drop_data, add_data_o, add_data_oe;
  wire [2:0] drop_h4_mark;
  wire irq, drop_clk, drop_par, add_clk, add_par_oe, add_ind_o, proc_clk_reg;
  integer n_fail = 0;
  integer samples_checked = 0;
  integer cyc = 0;
  integer i;
  always #4 mclk = ~mclk;
  always #9 if (desync_en) desync_clock_input = ~desync_clock_input;
  bam_drop_source u_src (.drop_en(drop_en), .add_en(add_en), .par_bad(par_bad), .h4_bad(h4_bad),
    .drop_clk(drop_clk), .drop_data(drop_data), .drop_par(drop_par), .drop_h4_mark(drop_h4_mark),
    .add_clk(add_clk));
  bam_monitor u_dut (.mclk(mclk), .rst_b(rst_b), .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .drop_clk(drop_clk),
    .drop_data(drop_data), .drop_par(drop_par), .drop_h4_mark(drop_h4_mark), .add_clk(add_clk),
    .ais_pointer(ais_pointer), .ais_overhead(ais_overhead), .desync_clock_input(desync_clock_input),
    .watchdog_expired(watchdog_expired), .iram_parity_error(iram_parity_error),
    .add_data_in(8'h5a), .add_par_in(1'b1), .add_ind_in(1'b1), .add_data_o(add_data_o),
    .add_data_oe(add_data_oe), .add_par_o(), .add_par_oe(add_par_oe), .add_ind_o(add_ind_o),
    .proc_clk_reg(proc_clk_reg));
  ////////////////////////////////////////////////////////////////////////////////
  task step(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] m, input [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & m, e);
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    rd(8'h29, 8'hff, 8'h07);
    rd(8'h28, 8'hff, 8'h07);
    rd(8'h27, 8'hff, 8'h00);
    rd(8'h40, 8'hff, 8'h00);
    $display("reset test done");
  endtask
  task t_dloc;
    step(150);
    rd(8'h27, 8'h80, 8'h80);
    chk(add_data_oe, 8'h00);
    chk({add_ind_o, add_par_oe}, 8'h00);
    drop_en <= 1'b1;
    step(24);
    rd(8'h27, 8'h80, 8'h00);
    chk(add_data_oe, 8'hff);
    chk(add_data_o, 8'h5a);
    $display("drop clock loss test done");
  endtask
  task t_aloc;
    add_en <= 1'b0;
    step(200);
    rd(8'h27, 8'h40, 8'h00);
    chk(add_data_oe, 8'hff);
    wr(8'h2a, 8'h04);
    step(4);
    rd(8'h27, 8'h40, 8'h40);
    chk({add_ind_o, add_par_oe}, 8'h00);
    add_en <= 1'b1;
    step(24);
    rd(8'h27, 8'h40, 8'h00);
    chk(add_data_oe, 8'hff);
    wr(8'h2a, 8'h00);
    $display("add clock loss test done");
  endtask
  task t_par;
    wr(8'h2c, 8'h00);
    wr(8'h2b, 8'hff);
    par_bad <= 1'b1;
    step(40);
    par_bad <= 1'b0;
    step(40);
    chk({7'h0, irq}, 8'h00);
    rd(8'h2b, 8'h20, 8'h20);
    chk(add_data_oe, 8'hff);
    wr(8'h2c, 8'h20);
    #1;
    chk({7'h0, irq}, 8'h01);
    wr(8'h2b, 8'h20);
    step(2);
    chk({7'h0, irq}, 8'h00);
    wr(8'h2c, 8'h00);
    $display("parity test done");
  endtask
  task t_ais;
    ais_pointer <= 3'h5;
    ais_overhead <= 3'h3;
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h2a, {4'h0, i[1], 2'h0, i[0]});
      step(4);
      rd(8'h27, 8'h07, (i[0] ? 8'h03 : 8'h05) & (i[1] ? 8'h01 : 8'h07));
    end
    wr(8'h2a, 8'h00);
    $display("ais test done");
  endtask
  task t_h4;
    step(1000);
    rd(8'h29, 8'h07, 8'h00);
    h4_bad <= 1'b1;
    step(1000);
    rd(8'h29, 8'h07, 8'h07);
    wr(8'h2a, 8'h08);
    step(4);
    rd(8'h29, 8'h07, 8'h01);
    wr(8'h2a, 8'h02);
    step(4);
    rd(8'h29, 8'h07, 8'h00);
    wr(8'h2a, 8'h00);
    h4_bad <= 1'b0;
    step(1000);
    rd(8'h29, 8'h07, 8'h00);
    $display("h4 test done");
  endtask
  task t_proc;
    watchdog_expired <= 1'b1;
    step(1);
    watchdog_expired <= 1'b0;
    iram_parity_error <= 1'b1;
    step(1);
    iram_parity_error <= 1'b0;
    step(3);
    rd(8'h29, 8'h50, 8'h00);
    rd(8'h28, 8'h50, 8'h50);
    wr(8'h2d, 8'h10);
    #1;
    chk({7'h0, irq}, 8'h01);
    wr(8'h28, 8'h50);
    rd(8'h28, 8'h50, 8'h00);
    chk({7'h0, irq}, 8'h00);
    wr(8'h2d, 8'h00);
    desync_en <= 1'b0;
    step(200);
    rd(8'h29, 8'h80, 8'h80);
    desync_en <= 1'b1;
    step(12);
    rd(8'h29, 8'h80, 8'h00);
    $display("processor test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      results;
    end
  end
  initial begin
    step(6);
    rst_b <= 1'b1;
    step(4);
    t_reset;
    t_dloc;
    t_aloc;
    t_par;
    t_ais;
    t_h4;
    t_proc;
    results;
  end
endmodule // bam_monitor_bench
bind bam_monitor bam_monitor_asserts u_ast (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .add_data_oe, .add_par_oe, .add_ind_o, .desync_clock_input, .proc_clk_reg);
